/* verilog/sfwp_regs.vh */
// Register map, field positions, opcodes, result codes and timing counts of the flash write-protect block.
`ifndef SFWP_REGS_VH
`define SFWP_REGS_VH

// Byte addresses of the APB registers.
`define SFWP_ADDR_STATUS  8'h00
`define SFWP_ADDR_CMD     8'h04
`define SFWP_ADDR_ARG     8'h08
`define SFWP_ADDR_DUMMY   8'h0c
`define SFWP_ADDR_RESULT  8'h10
`define SFWP_ADDR_PEEK    8'h14

// Status register field positions.
`define SFWP_ST_BUSY      0
`define SFWP_ST_WEL       1
`define SFWP_ST_BP_LSB    2
`define SFWP_ST_BP_MSB    6
`define SFWP_ST_SRP0      7
`define SFWP_ST_SRP1      8
`define SFWP_ST_WPS       9
`define SFWP_ST_DPD       10
`define SFWP_ST_SUSP      11

// Command register fields.
`define SFWP_CMD_OP_MSB   7
`define SFWP_CMD_LEN_LSB  8
`define SFWP_CMD_LEN_MSB  23

// Opcodes.
`define SFWP_OP_SET_WEL   8'h06
`define SFWP_OP_CLR_WEL   8'h04
`define SFWP_OP_WR_STATUS 8'h01
`define SFWP_OP_PROGRAM   8'h02
`define SFWP_OP_PAGE_ERS  8'h81
`define SFWP_OP_SECT_ERS  8'h20
`define SFWP_OP_B32_ERS   8'h52
`define SFWP_OP_B64_ERS   8'hd8
`define SFWP_OP_CHIP_ERS  8'hc7
`define SFWP_OP_DEEP_PD   8'hb9
`define SFWP_OP_WAKE      8'hab
`define SFWP_OP_SUSPEND   8'h75
`define SFWP_OP_RESUME    8'h7a

// Expected command lengths in bits.
`define SFWP_LEN_OP       16'h0008
`define SFWP_LEN_ADDR     16'h0020
`define SFWP_LEN_STATUS   16'h0018

// Result codes of the last command.
`define SFWP_RES_OK       3'h0
`define SFWP_RES_LENGTH   3'h1
`define SFWP_RES_NO_WEL   3'h2
`define SFWP_RES_PROTECT  3'h3
`define SFWP_RES_DPD      3'h4
`define SFWP_RES_BUSY     3'h5
`define SFWP_RES_UNKNOWN  3'h6

// Reset value and array top address.
`define SFWP_DUMMY_RESET  2'h3
`define SFWP_ARRAY_TOP    19'h7ffff

// Timing: figures in their own unit, counts derived from the clock rate.
`define SFWP_CLK_MHZ      100
`define SFWP_T_PROG_US    2000
`define SFWP_T_ERASE_US   16000
`define SFWP_T_WRSR_US    8000
`define SFWP_T_SUSP_US    30
`define SFWP_SUSP_CYCLES  (`SFWP_T_SUSP_US * `SFWP_CLK_MHZ)

`endif

/* verilog/sfwp_prot_decode.v */
// Block-protect decoder: maps the protect bits onto the protected address window.
`timescale 1ns/100ps
`default_nettype none
`include "sfwp_regs.vh"

module sfwp_prot_decode (
   // Protect configuration.
   input  wire [4:0]  protect_bits,
   input  wire        protect_scheme_select,
   // Protected window.
   output reg         prot_none,
   output reg  [18:0] prot_lo,
   output reg  [18:0] prot_hi
);

   reg [4:0]  size_lg;
   reg [19:0] full_mask;

   // Size as a power of two; bit 3 picks bottom or top of the array.
   always @* begin
      size_lg   = 5'h0;
      prot_none = 1'b0;
      if (protect_scheme_select) begin
         size_lg = 5'h13; // Lock bits all default set, so the whole array stays locked.
      end else if (!protect_bits[4]) begin
         if (protect_bits[2:0] == 3'h0)
            prot_none = 1'b1;
         else if (protect_bits[2])
            size_lg = 5'h13;
         else
            size_lg = 5'h0f + {3'h0, protect_bits[1:0]}; // 64KB, 128KB, 256KB.
      end else begin
         case (protect_bits[2:0])
            3'h0: prot_none = 1'b1;
            3'h1: size_lg = 5'h0c;
            3'h2: size_lg = 5'h0d;
            3'h3: size_lg = 5'h0e;
            3'h7: size_lg = 5'h13;
            default: size_lg = 5'h0f; // Codes 100, 101 and 110 all give 32KB.
         endcase
      end
      full_mask = (20'h00001 << size_lg) - 20'h00001;
      if (protect_bits[3] && !protect_scheme_select) begin
         prot_lo = 19'h0;
         prot_hi = full_mask[18:0];
      end else begin
         prot_lo = ~full_mask[18:0];
         prot_hi = `SFWP_ARRAY_TOP;
      end
   end

endmodule

`default_nettype wire

/* verilog/sfwp_top.v */
// Flash write-protect and program/erase controller with an APB register port.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "sfwp_regs.vh"

module sfwp_top #(
   parameter [31:0] PROG_CYCLES  = `SFWP_T_PROG_US * `SFWP_CLK_MHZ,
   parameter [31:0] ERASE_CYCLES = `SFWP_T_ERASE_US * `SFWP_CLK_MHZ,
   parameter [31:0] WRSR_CYCLES  = `SFWP_T_WRSR_US * `SFWP_CLK_MHZ
) (
   // Clock and reset.
   input  wire        pclk,
   input  wire        presetn,
   // APB slave.
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Pins and status.
   input  wire        wp_n,
   output reg         busy,
   output reg  [3:0]  dummy_cycles
);

   // One-hot controller states.
   localparam [4:0] ST_IDLE    = 5'h01;
   localparam [4:0] ST_BUSY    = 5'h02;
   localparam [4:0] ST_SUSPING = 5'h04;
   localparam [4:0] ST_SUSPEND = 5'h08;
   localparam [4:0] ST_DPD     = 5'h10;
   // Kinds of long operation.
   localparam [1:0] KIND_NONE   = 2'h0;
   localparam [1:0] KIND_PROG   = 2'h1;
   localparam [1:0] KIND_ERASE  = 2'h2;
   localparam [1:0] KIND_STATUS = 2'h3;
   localparam [31:0] SUSP_LOAD  = `SFWP_SUSP_CYCLES - 1;

   reg  [4:0]   state_reg;
   reg  [21:0]  op_cnt_reg;
   reg  [21:0]  susp_cnt_reg;
   reg  [1:0]   kind_reg;
   reg  [4:0]   lg_reg;
   reg  [18:0]  start_reg;
   reg  [18:0]  end_reg;
   reg  [9:0]   data_reg;
   reg          lock_reg;
   reg          wel_reg;
   reg  [4:0]   bp_reg;
   reg  [1:0]   srp_reg;
   reg          wps_reg;
   reg  [23:0]  cmd_reg;
   reg  [18:0]  arg_reg;
   reg  [1:0]   dummy_reg;
   reg  [2:0]   result_reg;
   reg  [127:0] blank_reg;
   reg          wp_meta_reg;
   reg          wp_sync_reg;
   reg  [15:0]  exp_len;
   reg          needs_wel;
   reg          known;
   reg  [1:0]   kind;
   reg  [4:0]   tgt_lg;
   reg  [19:0]  tgt_full;
   reg  [18:0]  tgt_start;
   reg  [18:0]  tgt_end;
   reg  [31:0]  rd_mux;
   reg          addr_ok;
   wire         prot_none;
   wire [18:0]  prot_lo;
   wire [18:0]  prot_hi;
   wire [7:0]   op      = pwdata[`SFWP_CMD_OP_MSB:0];
   wire [15:0]  cmd_len = pwdata[`SFWP_CMD_LEN_MSB:`SFWP_CMD_LEN_LSB];
   wire         access  = psel & penable & pready;
   wire         cmd_go  = access & pwrite & (paddr == `SFWP_ADDR_CMD);
   wire         len_ok  = (cmd_len[2:0] == 3'h0) && (cmd_len == exp_len);
   wire         hits    = !prot_none && (tgt_start <= prot_hi) && (tgt_end >= prot_lo);
   wire         op_done = (state_reg[1] || state_reg[2]) && (op_cnt_reg == 22'h0);
   wire [31:0]  status_word;

   sfwp_prot_decode u_decode (
      .protect_bits          (bp_reg),
      .protect_scheme_select (wps_reg),
      .prot_none             (prot_none),
      .prot_lo               (prot_lo),
      .prot_hi               (prot_hi)
   );

   // The pin is asynchronous to pclk, so it passes two flops before use.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_meta_reg <= 1'b1;
         wp_sync_reg <= 1'b1;
      end else begin
         wp_meta_reg <= wp_n;
         wp_sync_reg <= wp_meta_reg;
      end
   end

   // Opcode table: expected length, latch need, and the target range size.
   always @* begin
      exp_len   = `SFWP_LEN_OP;
      needs_wel = 1'b0;
      known     = 1'b1;
      kind      = KIND_NONE;
      tgt_lg    = 5'h0;
      case (op)
         `SFWP_OP_SET_WEL, `SFWP_OP_CLR_WEL, `SFWP_OP_DEEP_PD,
         `SFWP_OP_WAKE, `SFWP_OP_SUSPEND, `SFWP_OP_RESUME: begin
            known = 1'b1;
         end
         `SFWP_OP_WR_STATUS: begin
            exp_len   = `SFWP_LEN_STATUS;
            needs_wel = 1'b1;
            kind      = KIND_STATUS;
         end
         `SFWP_OP_PROGRAM: begin
            exp_len   = `SFWP_LEN_ADDR;
            needs_wel = 1'b1;
            kind      = KIND_PROG;
            tgt_lg    = 5'h08;
         end
         `SFWP_OP_PAGE_ERS, `SFWP_OP_SECT_ERS, `SFWP_OP_B32_ERS, `SFWP_OP_B64_ERS: begin
            exp_len   = `SFWP_LEN_ADDR;
            needs_wel = 1'b1;
            kind      = KIND_ERASE;
            tgt_lg    = (op == `SFWP_OP_PAGE_ERS) ? 5'h08 : (op == `SFWP_OP_SECT_ERS) ? 5'h0c :
                        (op == `SFWP_OP_B32_ERS) ? 5'h0f : 5'h10;
         end
         `SFWP_OP_CHIP_ERS: begin
            needs_wel = 1'b1;
            kind      = KIND_ERASE;
            tgt_lg    = 5'h13;
         end
         default: begin
            known = 1'b0;
         end
      endcase
      tgt_full  = (20'h00001 << tgt_lg) - 20'h00001;
      tgt_start = arg_reg & ~tgt_full[18:0];
      tgt_end   = tgt_start | tgt_full[18:0];
   end

   // Command engine and long-operation timing.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg    <= ST_IDLE;
         busy         <= 1'b0;
         op_cnt_reg   <= 22'h0;
         susp_cnt_reg <= 22'h0;
         kind_reg     <= KIND_NONE;
         lg_reg       <= 5'h0;
         start_reg    <= 19'h0;
         end_reg      <= 19'h0;
         data_reg     <= 10'h0;
         lock_reg     <= 1'b0;
         wel_reg      <= 1'b0;
         bp_reg       <= 5'h0;
         srp_reg      <= 2'h0;
         wps_reg      <= 1'b0;
         result_reg   <= `SFWP_RES_OK;
      end else begin
         if (op_done) begin
            // Completion applies status writes and clears the latch.
            state_reg <= ST_IDLE;
            busy      <= 1'b0;
            wel_reg   <= 1'b0;
            if (kind_reg == KIND_STATUS) begin
               wps_reg <= data_reg[`SFWP_ST_WPS-`SFWP_ST_BP_LSB];
               if (!lock_reg) begin
                  bp_reg  <= data_reg[4:0];
                  srp_reg <= data_reg[6:5];
               end
            end
         end else if (state_reg[1] || state_reg[2]) begin
            op_cnt_reg <= op_cnt_reg - 22'h1;
         end
         if (state_reg[2] && !op_done) begin
            if (susp_cnt_reg == 22'h0) begin
               state_reg <= ST_SUSPEND; // Suspend lands within 30 us.
               busy      <= 1'b0;
            end else begin
               susp_cnt_reg <= susp_cnt_reg - 22'h1;
            end
         end
         if (cmd_go) begin
            if (state_reg[4]) begin
               // Deep power-down ignores everything but the wake command.
               if ((op == `SFWP_OP_WAKE) && len_ok) begin
                  state_reg  <= ST_IDLE;
                  result_reg <= `SFWP_RES_OK;
               end else begin
                  result_reg <= `SFWP_RES_DPD;
               end
            end else if (!known) begin
               result_reg <= `SFWP_RES_UNKNOWN;
            end else if (!len_ok) begin
               result_reg <= `SFWP_RES_LENGTH;
               if (needs_wel && state_reg[0])
                  wel_reg <= 1'b0;
            end else if (state_reg[1] || state_reg[2]) begin
               if ((op == `SFWP_OP_SUSPEND) && state_reg[1] && (kind_reg != KIND_STATUS)) begin
                  state_reg    <= ST_SUSPING;
                  susp_cnt_reg <= SUSP_LOAD[21:0];
                  result_reg   <= `SFWP_RES_OK;
               end else begin
                  result_reg <= `SFWP_RES_BUSY;
               end
            end else if (state_reg[3]) begin
               if (op == `SFWP_OP_RESUME) begin
                  state_reg  <= ST_BUSY;
                  busy       <= 1'b1;
                  result_reg <= `SFWP_RES_OK;
               end else if (op == `SFWP_OP_SET_WEL || op == `SFWP_OP_CLR_WEL) begin
                  wel_reg    <= (op == `SFWP_OP_SET_WEL);
                  result_reg <= `SFWP_RES_OK;
               end else begin
                  result_reg <= `SFWP_RES_BUSY;
               end
            end else if (op == `SFWP_OP_SET_WEL || op == `SFWP_OP_CLR_WEL) begin
               wel_reg    <= (op == `SFWP_OP_SET_WEL);
               result_reg <= `SFWP_RES_OK;
            end else if (op == `SFWP_OP_DEEP_PD) begin
               state_reg  <= ST_DPD;
               result_reg <= `SFWP_RES_OK;
            end else if (!needs_wel) begin
               result_reg <= `SFWP_RES_OK;
            end else if (!wel_reg) begin
               result_reg <= `SFWP_RES_NO_WEL;
            end else if ((kind != KIND_STATUS) && hits) begin
               result_reg <= `SFWP_RES_PROTECT;
               wel_reg    <= 1'b0;
            end else begin
               // Accepted: busy for the typical time of the operation.
               state_reg  <= ST_BUSY;
               busy       <= 1'b1;
               kind_reg   <= kind;
               lg_reg     <= tgt_lg;
               start_reg  <= tgt_start;
               end_reg    <= tgt_end;
               data_reg   <= arg_reg[11:2];
               lock_reg   <= !wp_sync_reg; // Pin low at acceptance freezes BP and SRP; WPS is written regardless.
               result_reg <= `SFWP_RES_OK;
               op_cnt_reg <= (kind == KIND_PROG) ? PROG_CYCLES[21:0] - 22'h1 :
                             (kind == KIND_ERASE) ? ERASE_CYCLES[21:0] - 22'h1 : WRSR_CYCLES[21:0] - 22'h1;
            end
         end
      end
   end

   // Per-sector blank flags stand in for the array: erased sectors read FFh.
   genvar gi;
   generate
      for (gi = 0; gi < 128; gi = gi + 1) begin : g_sector
         localparam [31:0] SEC = gi;
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               blank_reg[gi] <= 1'b1;
            end else if (op_done && (kind_reg == KIND_ERASE) && (lg_reg >= 5'h0c) &&
                         (SEC[6:0] >= start_reg[18:12]) && (SEC[6:0] <= end_reg[18:12])) begin
               blank_reg[gi] <= 1'b1;
            end else if (op_done && (kind_reg == KIND_PROG) && (SEC[6:0] == start_reg[18:12])) begin
               blank_reg[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   assign status_word = {20'h0, state_reg[3], state_reg[4], wps_reg, srp_reg, bp_reg, wel_reg, busy};

   // Read mux; an unmapped address reads zero and raises pslverr.
   always @* begin
      addr_ok = 1'b1;
      case (paddr)
         `SFWP_ADDR_STATUS: rd_mux = status_word;
         `SFWP_ADDR_CMD:    rd_mux = {8'h0, cmd_reg};
         `SFWP_ADDR_ARG:    rd_mux = {13'h0, arg_reg};
         `SFWP_ADDR_DUMMY:  rd_mux = {26'h0, dummy_cycles, dummy_reg};
         `SFWP_ADDR_RESULT: rd_mux = {29'h0, result_reg};
         `SFWP_ADDR_PEEK:   rd_mux = {24'h0, {8{blank_reg[arg_reg[18:12]]}}};
         default: begin
            rd_mux  = 32'h0;
            addr_ok = 1'b0;
         end
      endcase
   end

   // APB slave: one wait state, so every access answers in its second cycle.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready       <= 1'b0;
         pslverr      <= 1'b0;
         prdata       <= 32'h0;
         cmd_reg      <= 24'h0;
         arg_reg      <= 19'h0;
         dummy_reg    <= `SFWP_DUMMY_RESET; // Ten cycles by default.
         dummy_cycles <= 4'ha;
      end else begin
         pready  <= psel & penable & !pready;
         pslverr <= psel & penable & !pready & !addr_ok;
         prdata  <= (psel & penable & !pready & !pwrite) ? rd_mux : 32'h0;
         if (access && pwrite) begin
            if (paddr == `SFWP_ADDR_CMD)
               cmd_reg <= pwdata[23:0];
            if (paddr == `SFWP_ADDR_ARG)
               arg_reg <= pwdata[18:0];
            if (paddr == `SFWP_ADDR_DUMMY) begin
               dummy_reg    <= pwdata[1:0];
               dummy_cycles <= {1'b0, pwdata[1:0], 1'b0} + 4'h4; // 4, 6, 8 or 10.
            end
         end
      end
   end

endmodule

`default_nettype wire

/* tb/sfwp_assertions.sv */
// Concurrent checks on the APB port, busy flag and dummy count of the write-protect block.
`timescale 1ns/100ps
`default_nettype none
`include "sfwp_regs.vh"
module sfwp_assertions #(
   parameter [31:0] PROG_CYCLES  = 32'd20,
   parameter [31:0] ERASE_CYCLES = 32'd40,
   parameter [31:0] WRSR_CYCLES  = 32'd30
) (
   // Clock and reset.
   input wire logic        pclk,
   input wire logic        presetn,
   // APB slave.
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Pins and status.
   input wire logic        wp_n,
   input wire logic        busy,
   input wire logic [3:0]  dummy_cycles
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // A completed write to the dummy register and the count its code should give.
   wire       dummy_wr  = psel && penable && pready && pwrite && (paddr == `SFWP_ADDR_DUMMY);
   wire [3:0] dummy_exp = {1'b0, pwdata[1:0], 1'b0} + 4'h4;
   // A suspend issued while busy; a rejected one simply lets busy run out, which is shorter.
   wire       susp_wr   = psel && penable && pready && pwrite && (paddr == `SFWP_ADDR_CMD) &&
                          (pwdata[23:0] == 24'h000875) && busy;
   reg [31:0] busy_cnt;
   reg [15:0] susp_cnt;
   reg        susp_pend;

   // Counts the length of each busy run and of each pending suspend.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_cnt  <= 32'h0;
         susp_cnt  <= 16'h0;
         susp_pend <= 1'b0;
      end else begin
         busy_cnt  <= busy ? busy_cnt + 32'h1 : 32'h0;
         susp_pend <= susp_wr ? 1'b1 : (busy ? susp_pend : 1'b0);
         susp_cnt  <= susp_pend ? susp_cnt + 16'h1 : 16'h0;
      end
   end

   property p_rst_state;
      $rose(presetn) |-> !busy && (dummy_cycles == 4'ha) && !pready;
   endproperty
   a_rst_state: assert property (p_rst_state) else $error("busy or dummy count wrong after reset");
   property p_dummy_legal;
      dummy_cycles inside {4'h4, 4'h6, 4'h8, 4'ha};
   endproperty
   a_dummy_legal: assert property (p_dummy_legal) else $error("dummy count not 4, 6, 8 or 10");
   property p_dummy_write;
      dummy_wr |=> dummy_cycles == $past(dummy_exp);
   endproperty
   a_dummy_write: assert property (p_dummy_write) else $error("dummy count does not follow its code");
   property p_busy_bound;
      busy |-> busy_cnt < (ERASE_CYCLES * 32'd15) / 32'd8;
   endproperty
   a_busy_bound: assert property (p_busy_bound) else $error("busy held past the maximum time");
   property p_susp_bound;
      susp_cnt <= `SFWP_SUSP_CYCLES + 1;
   endproperty
   a_susp_bound: assert property (p_susp_bound) else $error("suspend latency too long");
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
   property p_ready_cause;
      pready |-> psel && penable && $past(penable);
   endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("pready outside a second access cycle");
   property p_err_addr;
      pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14});
   endproperty
   a_err_addr: assert property (p_err_addr) else $error("pslverr does not match address decode");
   property p_rdata_idle;
      !pready |-> prdata == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside pready");
endmodule
`default_nettype wire

/* tb/sfwp_host.sv */
// Behavioural APB host standing in for the flash controller on the far side.
`timescale 1ns/100ps
`default_nettype none
`include "sfwp_regs.vh"
module sfwp_host (
   // Clock.
   input  wire logic        pclk,
   // APB master.
   output var  logic        psel,
   output var  logic        penable,
   output var  logic        pwrite,
   output var  logic [7:0]  paddr,
   output var  logic [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready
);
   // The bus starts deselected.
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
   end

   // One transfer, entered just after an edge; the request holds until pready is sampled.
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      // Released lines show the inverse so a stale value can never pass.
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~a;
      pwdata  <= ~d;
      @(posedge pclk);
   endtask

   // Issues a command; data-changing ones get the latch set first when asked.
   task automatic cmd(input logic [7:0] op, input logic [15:0] len, input logic lat, input logic [31:0] arg);
      logic [31:0] r;
      xfer(1'b1, `SFWP_ADDR_ARG, arg, r);
      if (lat) xfer(1'b1, `SFWP_ADDR_CMD, 32'h00000806, r);
      xfer(1'b1, `SFWP_ADDR_CMD, {8'h00, len, op}, r);
   endtask
endmodule
`default_nettype wire

/* tb/sfwp_top_test.sv */
// Self-checking bench for the flash write-protect block.
`timescale 1ns/100ps
`default_nettype none
`include "sfwp_regs.vh"
module sfwp_top_test;
   typedef struct packed { logic [4:0] bp; logic [18:0] adr; logic [2:0] res; } sfwp_row_t;
   localparam logic [2:0] RP = `SFWP_RES_PROTECT;
   localparam logic [2:0] RK = `SFWP_RES_OK;
   localparam int PROG = 3200;
   localparam int ERASE = 3200;
   // Protect code, program address and the result it should give.
   sfwp_row_t rows [20] = '{
      '{5'h00, 19'h00000, RK}, '{5'h04, 19'h00000, RP}, '{5'h1f, 19'h40000, RP}, '{5'h0c, 19'h7ff00, RP},
      '{5'h01, 19'h70000, RP}, '{5'h01, 19'h6ff00, RK}, '{5'h0a, 19'h1ff00, RP}, '{5'h0a, 19'h20000, RK},
      '{5'h03, 19'h40000, RP}, '{5'h11, 19'h7f000, RP}, '{5'h11, 19'h7ef00, RK}, '{5'h1b, 19'h03f00, RP},
      '{5'h1b, 19'h04000, RK}, '{5'h15, 19'h78000, RP}, '{5'h1e, 19'h07f00, RP}, '{5'h1e, 19'h08000, RK},
      '{5'h02, 19'h5ff00, RK}, '{5'h0b, 19'h3ff00, RP}, '{5'h12, 19'h7e000, RP}, '{5'h19, 19'h01000, RK}};
   logic [7:0]  ers [5] = '{8'h81, 8'h20, 8'h52, 8'hd8, 8'hc7};
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        wp_n = 1'b1;
   wire         psel, penable, pwrite, pready;
   wire  [7:0]  paddr;
   wire  [31:0] pwdata, prdata;
   wire         busy;
   wire  [3:0]  dummy_cycles;
   logic [31:0] rd;
   int          num_errors = 0;
   int          checked = 0;
   int          n;

   // Free-running 100 MHz clock.
   always #5 pclk = ~pclk;

   sfwp_top #(.PROG_CYCLES(32'd3200), .ERASE_CYCLES(32'd3200), .WRSR_CYCLES(32'd30)) u_sfwp_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(), .wp_n(wp_n), .busy(busy),
      .dummy_cycles(dummy_cycles));
   sfwp_host u_sfwp_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready));

   // Prints the verdict and ends the run.
   task automatic test_done;
      if (num_errors == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Compares a value and reports a mismatch.
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // Reads a register and compares it.
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      u_sfwp_host.xfer(1'b0, a, 32'h0, rd);
      check(what, exp, rd);
   endtask
   // Counts edges while busy; the bound keeps a stuck flag from hanging the run.
   task automatic busy_len(input int lo, input int hi);
      n = 0;
      while (busy === 1'b1 && n < 8000) begin
         @(posedge pclk);
         n++;
      end
      checked++;
      if (n < lo || n > hi) begin
         num_errors++;
         $display("unexpected busy cycles: expected %0d..%0d, seen %0d", lo, hi, n);
      end
   endtask
   // Writes status bits 9..2 through a status write and waits for it.
   task automatic set_bp(input logic [7:0] bp);
      u_sfwp_host.cmd(`SFWP_OP_WR_STATUS, `SFWP_LEN_STATUS, 1'b1, {22'h0, bp, 2'b00});
      busy_len(0, 60);
   endtask

   // Hang guard, about twice the cycles the tests should take.
   initial begin
      #1000000;
      num_errors++;
      test_done();
   end

   // Main sequence; the host keeps select off until reset is over.
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk("status", `SFWP_ADDR_STATUS, 32'h0);
      foreach (rows[i]) begin
         set_bp(rows[i].bp);
         rd_chk("status", `SFWP_ADDR_STATUS, {25'h0, rows[i].bp, 2'b00});
         u_sfwp_host.cmd(`SFWP_OP_PROGRAM, `SFWP_LEN_ADDR, 1'b1, {13'h0, rows[i].adr});
         rd_chk("result", `SFWP_ADDR_RESULT, {29'h0, rows[i].res});
         busy_len(0, PROG * 3 / 2);
         rd_chk("status", `SFWP_ADDR_STATUS, {25'h0, rows[i].bp, 2'b00});
      end
      set_bp(5'h00);
      u_sfwp_host.cmd(8'h06, 16'h0009, 1'b0, 32'h0);
      rd_chk("result", `SFWP_ADDR_RESULT, 32'h1);
      u_sfwp_host.cmd(`SFWP_OP_PROGRAM, 16'h001f, 1'b1, 32'h1000);
      rd_chk("result", `SFWP_ADDR_RESULT, 32'h1);
      rd_chk("status", `SFWP_ADDR_STATUS, 32'h0);
      u_sfwp_host.cmd(`SFWP_OP_PROGRAM, `SFWP_LEN_ADDR, 1'b0, 32'h1000);
      rd_chk("result", `SFWP_ADDR_RESULT, 32'h2);
      rd_chk("status", `SFWP_ADDR_STATUS, 32'h0);
      u_sfwp_host.cmd(`SFWP_OP_PROGRAM, `SFWP_LEN_ADDR, 1'b1, 32'h2000);
      busy_len(PROG - 1, PROG * 3 / 2);
      rd_chk("peek", `SFWP_ADDR_PEEK, 32'h0);
      // Every erase kind, each timed against its typical and maximum figure.
      foreach (ers[k]) begin
         u_sfwp_host.cmd(ers[k], (ers[k] == 8'hc7) ? `SFWP_LEN_OP : `SFWP_LEN_ADDR, 1'b1, 32'h2000);
         busy_len(ERASE - 1, ERASE * 30 / 16);
      end
      rd_chk("peek", `SFWP_ADDR_PEEK, 32'hff);
      wp_n <= 1'b0;
      repeat (3) @(posedge pclk);
      set_bp(5'h1f);
      rd_chk("status", `SFWP_ADDR_STATUS, 32'h0);
      wp_n <= 1'b1;
      u_sfwp_host.cmd(`SFWP_OP_DEEP_PD, `SFWP_LEN_OP, 1'b0, 32'h0);
      u_sfwp_host.cmd(8'h06, `SFWP_LEN_OP, 1'b0, 32'h0);
      rd_chk("result", `SFWP_ADDR_RESULT, 32'h4);
      rd_chk("status", `SFWP_ADDR_STATUS, 32'h400);
      u_sfwp_host.cmd(`SFWP_OP_WAKE, `SFWP_LEN_OP, 1'b0, 32'h0);
      rd_chk("status", `SFWP_ADDR_STATUS, 32'h0);
      // Suspend a program, refuse work while suspended, then resume; no second suspend follows.
      u_sfwp_host.cmd(`SFWP_OP_PROGRAM, `SFWP_LEN_ADDR, 1'b1, 32'h3000);
      u_sfwp_host.cmd(`SFWP_OP_SUSPEND, `SFWP_LEN_OP, 1'b0, 32'h3000);
      busy_len(0, `SFWP_SUSP_CYCLES + 1);
      u_sfwp_host.xfer(1'b0, `SFWP_ADDR_STATUS, 32'h0, rd);
      check("suspended", 32'h800, rd & 32'h801);
      u_sfwp_host.cmd(`SFWP_OP_CHIP_ERS, `SFWP_LEN_OP, 1'b1, 32'h3000);
      rd_chk("result", `SFWP_ADDR_RESULT, 32'h5);
      u_sfwp_host.cmd(`SFWP_OP_RESUME, `SFWP_LEN_OP, 1'b0, 32'h3000);
      busy_len(1, PROG * 3 / 2);
      rd_chk("status", `SFWP_ADDR_STATUS, 32'h0);
      for (int c = 0; c < 4; c++) begin
         u_sfwp_host.xfer(1'b1, `SFWP_ADDR_DUMMY, c, rd);
         check("dummy cycles", 32'(4 + 2 * c), {28'h0, dummy_cycles});
         rd_chk("dummy", `SFWP_ADDR_DUMMY, 32'((4 + 2 * c) * 4 + c));
      end
      u_sfwp_host.xfer(1'b1, `SFWP_ADDR_STATUS, 32'hffffffff, rd);
      rd_chk("status", `SFWP_ADDR_STATUS, 32'h0);
      rd_chk("unmapped", 8'h18, 32'h0);
      set_bp(8'h80);
      u_sfwp_host.cmd(`SFWP_OP_SECT_ERS, `SFWP_LEN_ADDR, 1'b1, 32'h0);
      rd_chk("result", `SFWP_ADDR_RESULT, 32'h3);
      // A second reset in mid-run restores idle, blank and default state.
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("dummy cycles", 32'ha, {28'h0, dummy_cycles});
      rd_chk("status", `SFWP_ADDR_STATUS, 32'h0);
      rd_chk("dummy", `SFWP_ADDR_DUMMY, 32'h2b);
      u_sfwp_host.xfer(1'b1, `SFWP_ADDR_ARG, 32'h3000, rd);
      rd_chk("peek", `SFWP_ADDR_PEEK, 32'hff);
      test_done();
   end
endmodule

bind sfwp_top sfwp_assertions #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES), .WRSR_CYCLES(WRSR_CYCLES))
   u_sfwp_assertions (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wp_n(wp_n),
   .busy(busy), .dummy_cycles(dummy_cycles));
`default_nettype wire
